// *** core/sss_pkg.sv ***
// constants, carrier types and states for the scan, sync and scroll command decoder
package sss_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SSS_CMD_SYNC_ON = 8'h35; // frame sync output on
  localparam logic [7:0] SSS_CMD_SCAN = 8'h36; // scan access control
  localparam logic [7:0] SSS_CMD_SCROLL = 8'h37; // scroll start line
  localparam logic [7:0] SSS_CMD_SCROLL_AREA = 8'h33; // area command, decoded elsewhere

  // ----------------------------------------------------------------
  // parameter bit positions
  // ----------------------------------------------------------------
  localparam int SSS_TE_MODE_BIT = 0; // te_line_select
  localparam int SSS_ROW_ORDER_BIT = 7;
  localparam int SSS_COL_ORDER_BIT = 6;
  localparam int SSS_SWAP_BIT = 5;
  localparam int SSS_VSCAN_BIT = 4;
  localparam int SSS_CFILT_BIT = 3;
  localparam int SSS_HSCAN_BIT = 2;
  localparam int SSS_BYTE_W = 8; // bus bits that carry meaning
  localparam int SSS_BUS_W = 24; // full width of the data pins

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SSS_SCROLL_RESET = 16'h0000;
  localparam logic [7:0] SSS_HI_RESET = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dc; // cmd_param_select
    logic rd_n; // read_strobe_n
    logic wr_n; // write_strobe_n
    logic [7:0] data; // low data byte
  } sss_pins_t;

  typedef struct packed {
    logic row_order;
    logic column_order;
    logic row_col_swap;
    logic vertical_scan_direction;
    logic color_filter_order;
    logic horizontal_scan_direction;
  } sss_scan_t;

  localparam sss_pins_t SSS_PINS_IDLE = '{dc: 1'h1, rd_n: 1'h1, wr_n: 1'h1, data: 8'h00};
  localparam sss_scan_t SSS_SCAN_RESET = '{default: 1'h0};

  typedef enum {SSS_IDLE, SSS_TE_PARAM, SSS_SCAN_PARAM, SSS_SCROLL_HI, SSS_SCROLL_LO} sss_state_t;

endpackage : sss_pkg

// *** core/sss_top.sv ***
// command decoder for frame sync output, scan access control and scroll start line
`timescale 1ns/10ps

module sss_top
  import sss_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_param_select,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [SSS_BUS_W-1:0] data_in,
  input wire logic sw_reset,
  input wire logic sleep_in,
  input wire logic vblank_in,
  input wire logic hblank_in,
  input wire logic frame_start,
  output logic frame_sync_output,
  output sss_scan_t scan_access_control,
  output logic [15:0] scroll_start_line
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  sss_pins_t sync1_reg; // first stage, read by second stage only
  sss_pins_t sync2_reg; // second stage
  sss_pins_t sync3_reg; // third stage
  sss_pins_t pins_now; // raw pin bundle
  logic wr_level_reg; // debounced strobe level
  logic wr_rise; // accepted rising strobe edge

  assign pins_now = '{dc: cmd_param_select, rd_n: read_strobe_n, wr_n: write_strobe_n,
                      data: data_in[SSS_BYTE_W-1:0]}; // upper data bits dropped

  // three stages for pins; data and select ride with the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_reg <= SSS_PINS_IDLE;
      sync2_reg <= SSS_PINS_IDLE;
      sync3_reg <= SSS_PINS_IDLE;
    end else begin
      sync1_reg <= pins_now;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // strobe level only moves once stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_level_reg <= 1'h1;
    end else if (sync2_reg.wr_n == sync3_reg.wr_n) begin
      wr_level_reg <= sync3_reg.wr_n;
    end
  end

  // a read in progress blocks the write, the host keeps it high
  assign wr_rise = (sync2_reg.wr_n == sync3_reg.wr_n) && sync3_reg.wr_n && !wr_level_reg
                   && sync3_reg.rd_n;

  // ----------------------------------------------------------------
  // byte capture
  // ----------------------------------------------------------------
  logic byte_valid_reg; // one-cycle pulse per written byte
  logic byte_param_reg; // byte was a parameter
  logic [7:0] byte_reg; // captured byte

  // data is taken from stage three, same age as the strobe edge
  always_ff @(posedge clock) begin
    if (srst) begin
      byte_valid_reg <= 1'h0;
      byte_param_reg <= 1'h0;
      byte_reg <= SSS_HI_RESET;
    end else begin
      byte_valid_reg <= wr_rise;
      if (wr_rise) begin
        byte_param_reg <= sync3_reg.dc;
        byte_reg <= sync3_reg.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  sss_state_t state_reg; // which parameter is awaited
  sss_state_t state_next;
  logic cmd_take; // command byte arrives
  logic param_take; // parameter byte arrives

  // map a command byte to the state that waits for its parameters
  function automatic sss_state_t sss_decode(input logic [7:0] code);
    sss_state_t st;
    st = SSS_IDLE;
    case (code)
      SSS_CMD_SYNC_ON: st = SSS_TE_PARAM;
      SSS_CMD_SCAN: st = SSS_SCAN_PARAM;
      SSS_CMD_SCROLL: st = SSS_SCROLL_HI;
      default: st = SSS_IDLE; // other commands belong to other blocks
    endcase
    return st;
  endfunction : sss_decode

  assign cmd_take = byte_valid_reg && !byte_param_reg && !sw_reset;
  assign param_take = byte_valid_reg && byte_param_reg && !sw_reset;

  // a command byte always restarts decode, even mid parameter list
  always_comb begin
    state_next = state_reg;
    if (sw_reset) begin
      state_next = SSS_IDLE;
    end else if (cmd_take) begin
      state_next = sss_decode(byte_reg);
    end else if (param_take) begin
      case (state_reg)
        SSS_TE_PARAM: state_next = SSS_IDLE;
        SSS_SCAN_PARAM: state_next = SSS_IDLE;
        SSS_SCROLL_HI: state_next = SSS_SCROLL_LO;
        SSS_SCROLL_LO: state_next = SSS_IDLE;
        default: state_next = SSS_IDLE; // stray parameters are dropped
      endcase
    end
  end

  // no power state gates decoding, sleep included
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= SSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  logic te_take; // sync-on parameter
  logic scan_take; // scan access parameter
  logic hi_take; // scroll high byte
  logic lo_take; // scroll low byte

  assign te_take = param_take && (state_reg == SSS_TE_PARAM);
  assign scan_take = param_take && (state_reg == SSS_SCAN_PARAM);
  assign hi_take = param_take && (state_reg == SSS_SCROLL_HI);
  assign lo_take = param_take && (state_reg == SSS_SCROLL_LO);

  // ----------------------------------------------------------------
  // frame sync output
  // ----------------------------------------------------------------
  logic te_enable_reg; // output enabled
  logic te_mode_reg; // horizontal blanking included
  logic fso_next;

  // stays on until a reset; the off command lives in another block
  always_ff @(posedge clock) begin
    if (srst || sw_reset) begin
      te_enable_reg <= 1'h0;
      te_mode_reg <= 1'h0;
    end else if (te_take) begin
      te_enable_reg <= 1'h1;
      te_mode_reg <= byte_reg[SSS_TE_MODE_BIT];
    end
  end

  // scan direction bits never enter this term
  always_comb begin
    fso_next = 1'h0;
    if (te_enable_reg && !sleep_in) begin
      if (te_mode_reg) begin
        fso_next = vblank_in || hblank_in;
      end else begin
        fso_next = vblank_in;
      end
    end // sleeping keeps the pin low
  end

  // registered so the pin never glitches on timing edges
  always_ff @(posedge clock) begin
    if (srst) begin
      frame_sync_output <= 1'h0;
    end else begin
      frame_sync_output <= fso_next;
    end
  end

  // ----------------------------------------------------------------
  // scan access control
  // ----------------------------------------------------------------
  // only its own fields move; sleep, idle and partial are elsewhere
  always_ff @(posedge clock) begin
    if (srst || sw_reset) begin
      scan_access_control <= SSS_SCAN_RESET;
    end else if (scan_take) begin
      scan_access_control.row_order <= byte_reg[SSS_ROW_ORDER_BIT];
      scan_access_control.column_order <= byte_reg[SSS_COL_ORDER_BIT];
      scan_access_control.row_col_swap <= byte_reg[SSS_SWAP_BIT];
      scan_access_control.vertical_scan_direction <= byte_reg[SSS_VSCAN_BIT];
      scan_access_control.color_filter_order <= byte_reg[SSS_CFILT_BIT];
      scan_access_control.horizontal_scan_direction <= byte_reg[SSS_HSCAN_BIT];
    end // bits 1 and 0 are simply not kept
  end

  // ----------------------------------------------------------------
  // scroll start line
  // ----------------------------------------------------------------
  logic [7:0] scroll_hi_reg; // staged high byte
  logic [15:0] scroll_pending_reg; // assembled, not yet shown
  logic pending_reg; // a new value waits for the next scan

  // high byte alone changes nothing visible
  always_ff @(posedge clock) begin
    if (srst || sw_reset) begin
      scroll_hi_reg <= SSS_HI_RESET;
    end else if (hi_take) begin
      scroll_hi_reg <= byte_reg;
    end
  end

  // new value arriving with a frame start waits for the following one
  always_ff @(posedge clock) begin
    if (srst || sw_reset) begin
      scroll_pending_reg <= SSS_SCROLL_RESET;
      pending_reg <= 1'h0;
    end else begin
      if (frame_start) begin
        pending_reg <= 1'h0;
      end
      if (lo_take) begin
        scroll_pending_reg <= {scroll_hi_reg, byte_reg};
        pending_reg <= 1'h1; // set beats the frame clear
      end
    end
  end

  // applied only on a scan boundary so a frame never tears
  always_ff @(posedge clock) begin
    if (srst || sw_reset) begin
      scroll_start_line <= SSS_SCROLL_RESET;
    end else if (frame_start && pending_reg) begin
      scroll_start_line <= scroll_pending_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // strobe edge that the synchroniser settles, before the read strobe gate
  sequence strobe_edge_seq;
    (sync2_reg.wr_n == sync3_reg.wr_n) && sync3_reg.wr_n && !wr_level_reg;
  endsequence

  sequence scroll_hi_seq;
    hi_take;
  endsequence

  sequence scroll_lo_seq;
    lo_take;
  endsequence

  // pin side: what the host writes reaches the decoder once, or not at all
  strobe_capture_a: assert property (wr_rise
                                     |=> byte_valid_reg && byte_reg == $past(sync3_reg.data))
    else $error("write strobe edge not captured");

  // a write that overlaps a read never reaches the decoder
  read_blocks_a: assert property (strobe_edge_seq ##0 !sync3_reg.rd_n
                                  |=> !byte_valid_reg)
    else $error("write during read was accepted");

  // a parameter with no command in front of it changes nothing
  stray_param_a: assert property (param_take && state_reg == SSS_IDLE
                                  |=> state_reg == SSS_IDLE && $stable(scan_access_control))
    else $error("stray parameter was not dropped");

  // frame sync output
  sync_enable_a: assert property (te_take
                                  |=> te_enable_reg
                                      && te_mode_reg == $past(byte_reg[SSS_TE_MODE_BIT]))
    else $error("sync on parameter not applied");

  vblank_only_a: assert property (te_enable_reg && !te_mode_reg && !vblank_in
                                  |=> !frame_sync_output)
    else $error("horizontal blanking leaked in vertical only mode");

  hblank_mix_a: assert property (te_enable_reg && te_mode_reg && !sleep_in && hblank_in
                                 |=> frame_sync_output)
    else $error("horizontal blanking missing");

  scan_keeps_sync_a: assert property (scan_take
                                      |=> $stable(te_enable_reg) && $stable(te_mode_reg))
    else $error("scan write disturbed sync output");

  sleep_low_a: assert property (sleep_in |=> !frame_sync_output)
    else $error("sync output not low in sleep");

  // scan access control
  scan_store_a: assert property (scan_take
                                 |=> scan_access_control
                                     == $past(byte_reg[SSS_ROW_ORDER_BIT:SSS_HSCAN_BIT]))
    else $error("scan access control not stored");

  scan_hold_a: assert property (!scan_take && !sw_reset
                                |=> $stable(scan_access_control))
    else $error("scan access control moved without its command");

  scan_isolated_a: assert property (scan_take && !frame_start
                                    |=> $stable(scroll_start_line) && $stable(scroll_pending_reg))
    else $error("scan write disturbed scroll state");

  // the high byte waits in its stage until the low byte completes the pair
  scroll_hi_a: assert property (scroll_hi_seq
                                |=> scroll_hi_reg == $past(byte_reg)
                                    && state_reg == SSS_SCROLL_LO)
    else $error("scroll high byte not staged");

  scroll_pair_a: assert property (scroll_lo_seq
                                  |=> scroll_pending_reg == {$past(scroll_hi_reg), $past(byte_reg)}
                                      && pending_reg)
    else $error("scroll bytes assembled wrongly");

  scroll_frame_a: assert property (!frame_start && !sw_reset
                                   |=> $stable(scroll_start_line))
    else $error("scroll line changed mid frame");

  scroll_apply_a: assert property (frame_start && pending_reg && !sw_reset
                                   |=> scroll_start_line == $past(scroll_pending_reg))
    else $error("pending scroll line not applied");

  // software reset returns every setting to its power-on value
  sw_clear_a: assert property (sw_reset
                               |=> !te_enable_reg && scan_access_control == SSS_SCAN_RESET
                                   && scroll_start_line == SSS_SCROLL_RESET && !pending_reg)
    else $error("software reset left a setting behind");

  sleep_decode_a: assert property (sleep_in && cmd_take && byte_reg == SSS_CMD_SCAN
                                   |=> state_reg == SSS_SCAN_PARAM)
    else $error("command refused in sleep");

endmodule : sss_top

// *** dv/sss_host_model.sv ***
// host processor model driving the parallel command bus
`timescale 1ns/10ps

module sss_host_model
  import sss_pkg::*;
(
  input wire logic clock,
  output logic cmd_param_select,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [SSS_BUS_W-1:0] data_in
);
  // ----------------------------------------------------------------
  // bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    cmd_param_select = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = '0;
  end

  // ----------------------------------------------------------------
  // one byte: strobe low 4 clocks, then high with data held
  // ----------------------------------------------------------------
  // upper lanes carry junk on purpose, the device must ignore them
  // rd_n low is only used to provoke a refused write
  // the host alone keeps start lines clear of fixed areas, and area
  // sizes summing to the line count; 33h goes out only once, to abort a scan list
  task automatic put_byte(input logic dc, input logic [7:0] val, input logic rd_n);
    @(posedge clock);
    cmd_param_select <= dc;
    read_strobe_n <= rd_n;
    data_in <= {16'hA5C3, val};
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clock);
    write_strobe_n <= 1'b1;
    // hold beyond the three synchroniser stages before letting go
    repeat (5) @(posedge clock);
    data_in <= ~{16'hA5C3, val};
    cmd_param_select <= ~dc;
    read_strobe_n <= 1'b1;
    repeat (3) @(posedge clock);
    cmd_param_select <= 1'b1;
  endtask : put_byte
endmodule : sss_host_model

// *** dv/scan_sync_scroll_commands_test.sv ***
// self-checking testbench for the scan, sync and scroll command decoder
`timescale 1ns/10ps

module scan_sync_scroll_commands_test;
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic sw_reset = 1'b0;
  logic sleep_in = 1'b0;
  logic vblank_in = 1'b0;
  logic hblank_in = 1'b0;
  logic frame_start = 1'b0;
  logic cmd_param_select;
  logic read_strobe_n;
  logic write_strobe_n;
  logic [SSS_BUS_W-1:0] data_in;
  logic frame_sync_output;
  sss_scan_t scan_access_control;
  logic [15:0] scroll_start_line;
  int n_errors = 0;
  int samples_checked = 0;
  int cycle_count = 0;
  logic [5:0] exp_scan; // expected scan fields

  always #20 clock = ~clock; // 25 MHz

  sss_host_model host (.clock(clock), .cmd_param_select(cmd_param_select),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in));

  sss_top dut (.clock(clock), .srst(srst), .cmd_param_select(cmd_param_select),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .sw_reset(sw_reset), .sleep_in(sleep_in), .vblank_in(vblank_in), .hblank_in(hblank_in),
    .frame_start(frame_start), .frame_sync_output(frame_sync_output),
    .scan_access_control(scan_access_control), .scroll_start_line(scroll_start_line));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // compare one value at a settled point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] c);
    host.put_byte(1'b0, c, 1'b1);
  endtask : cmd

  task automatic prm(input logic [7:0] p);
    host.put_byte(1'b1, p, 1'b1);
  endtask : prm

  // drive blanking and sleep, return sync output two edges later
  task automatic sync_set(input logic v, input logic h, input logic s);
    @(posedge clock);
    vblank_in <= v;
    hblank_in <= h;
    sleep_in <= s;
    repeat (2) @(negedge clock);
  endtask : sync_set

  // hang guard, whole run needs well under this
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(negedge clock);
    check({15'h0, frame_sync_output}, 16'h0000);
    check({10'h0, scan_access_control}, 16'h0000);
    check(scroll_start_line, SSS_SCROLL_RESET);
    // read strobe low refuses the command, the stray parameter is dropped
    host.put_byte(1'b0, SSS_CMD_SCAN, 1'b0);
    prm(8'h80);
    @(negedge clock);
    check({10'h0, scan_access_control}, 16'h0000);
    // sync on, vertical blanking only; unused bits set
    cmd(SSS_CMD_SYNC_ON);
    prm(8'hFE);
    sync_set(1'b1, 1'b0, 1'b0);
    check({15'h0, frame_sync_output}, 16'h0001);
    sync_set(1'b0, 1'b1, 1'b0);
    check({15'h0, frame_sync_output}, 16'h0000);
    // both blanking kinds
    cmd(SSS_CMD_SYNC_ON);
    prm(8'h01);
    sync_set(1'b0, 1'b1, 1'b0);
    check({15'h0, frame_sync_output}, 16'h0001);
    sync_set(1'b1, 1'b1, 1'b1);
    check({15'h0, frame_sync_output}, 16'h0000);
    // vertical scan bit must not disturb the sync output
    sync_set(1'b1, 1'b0, 1'b0);
    cmd(SSS_CMD_SCAN);
    prm(8'h10);
    @(negedge clock);
    check({15'h0, frame_sync_output}, 16'h0001);
    check({10'h0, scan_access_control}, 16'h0004);
    // walk every parameter bit while asleep, reserved bits last
    sync_set(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      cmd(SSS_CMD_SCAN);
      prm(8'h80 >> i);
      exp_scan = (i < 6) ? (6'h20 >> i) : 6'h00;
      @(negedge clock);
      check({10'h0, scan_access_control}, {10'h0, exp_scan});
      check({15'h0, frame_sync_output}, 16'h0000);
      check(scroll_start_line, 16'h0000);
    end
    sync_set(1'b1, 1'b0, 1'b0);
    // start line waits for the next scan
    cmd(SSS_CMD_SCROLL);
    prm(8'h01);
    @(negedge clock);
    check(scroll_start_line, 16'h0000);
    prm(8'hE0);
    @(negedge clock);
    check(scroll_start_line, 16'h0000);
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    repeat (2) @(negedge clock);
    check(scroll_start_line, 16'h01E0);
    // a command this block does not own aborts the scan list
    cmd(SSS_CMD_SCAN);
    cmd(SSS_CMD_SCROLL_AREA);
    prm(8'hFF);
    @(negedge clock);
    check({10'h0, scan_access_control}, 16'h0000);
    // software reset clears every setting
    @(posedge clock);
    sw_reset <= 1'b1;
    @(posedge clock);
    sw_reset <= 1'b0;
    repeat (2) @(negedge clock);
    check({15'h0, frame_sync_output}, 16'h0000);
    check({10'h0, scan_access_control}, 16'h0000);
    check(scroll_start_line, SSS_SCROLL_RESET);
    end_of_test();
  end
endmodule : scan_sync_scroll_commands_test
